// ---- gpio_port_defines.svh ----
// register map, field layout and reset values of the gpio port pin access block
// assumes byte addresses on a 32-bit word bus; every register is one aligned word
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// per-pin word registers, four bytes apart
`define WORD_BANK0_BASE   32'h5000_1000
`define WORD_BANK1_BASE   32'h5000_1080
`define WORD_PINS_BANK0   24
`define WORD_PINS_BANK1   32
`define WORD_STRIDE_LOG2  2

// per-port control and access registers
`define DIR_BANK0_ADDR    32'h5000_2000
`define DIR_BANK1_ADDR    32'h5000_2004
`define MASK_BANK0_ADDR   32'h5000_2080
`define MASK_BANK1_ADDR   32'h5000_2084
`define PIN_BANK0_ADDR    32'h5000_2100
`define PIN_BANK1_ADDR    32'h5000_2104
`define MPIN_BANK0_ADDR   32'h5000_2180
`define MPIN_BANK1_ADDR   32'h5000_2184

// reset values
`define DIR_RESET         32'h0000_0000
`define MASK_RESET        32'h0000_0000
`define OUT_RESET         32'h0000_0000
`define WORD_ALL_ONES     32'hFFFF_FFFF
`define WORD_ZERO         32'h0000_0000

`endif

// ---- gpio_port_pkg.sv ----
// types shared by the gpio port pin access block
// assumes the register map of gpio_port_defines.svh
package gpio_port_pkg;

  typedef logic [31:0] word_t;

  // one-hot register select produced by the address decoder
  typedef enum logic [10:0] {
    SEL_NONE  = 11'b000_0000_0001,
    SEL_WORD0 = 11'b000_0000_0010,
    SEL_WORD1 = 11'b000_0000_0100,
    SEL_DIRECTION_BANK0  = 11'b000_0000_1000,
    SEL_DIR1  = 11'b000_0001_0000,
    SEL_MASKED_ACCESS_ENABLE_BANK0 = 11'b000_0010_0000,
    SEL_MASKED_ACCESS_ENABLE_BANK1 = 11'b000_0100_0000,
    SEL_PIN_LEVEL_BANK0  = 11'b000_1000_0000,
    SEL_PIN_LEVEL_BANK1  = 11'b001_0000_0000,
    SEL_MPIN0 = 11'b010_0000_0000,
    SEL_MPIN1 = 11'b100_0000_0000
  } reg_sel_e;

endpackage : gpio_port_pkg

// ---- gpio_port_pin_access.sv ----
// gpio port pin access: two 32-pin ports with word, whole-port and masked access
// assumes a single 20 MHz clock; pin inputs are asynchronous; gpio and analog
// selects come from the pin configuration logic on the same clock
`timescale 1ns/100ps
`include "gpio_port_defines.svh"

// Overview of operation
// - word register reads give all zeros for low pin, all ones for high.
// - word register write of zero clears output bit; nonzero sets it.
// - first port has word registers for pins 0 to 23 from its base.
// - second port has word registers for pins 0 to 31 from its base.
// - each port has a 32-bit direction register; bit n steers pin n.
// - direction 0 means input, 1 means output; all reset to 0.
// - mask registers affect only masked-port accesses.
// - mask bit 0: masked read gives pin state, masked write loads output.
// - mask bit 1: masked read gives 0, masked write leaves output alone.
// - one mask register per port at fixed addresses, reset all zeros.
// - whole-port read gives pin levels regardless of direction, mask or digital function.
// - analog-selected pins always read as zero through pin registers.
// - whole-port write loads every output bit, ignoring mask.
// - whole-port bit n is pin n; 0 clears or reads low, 1 sets or reads high.
// - whole-port pin registers sit at two fixed addresses.
// - output bit drives pin only if gpio-selected and direction is output.
// - masked read equals pin states ANDed with inverted mask.
module gpio_port_pin_access
  import gpio_port_pkg::*;
#(
  parameter int WORD_PINS0 = `WORD_PINS_BANK0,
  parameter int WORD_PINS1 = `WORD_PINS_BANK1
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic [31:0] pin_in_bank0,
  input  wire logic [31:0] pin_in_bank1,
  input  wire logic [31:0] gpio_sel_bank0,
  input  wire logic [31:0] gpio_sel_bank1,
  input  wire logic [31:0] analog_sel_bank0,
  input  wire logic [31:0] analog_sel_bank1,
  output logic      [31:0] pin_out_bank0,
  output logic      [31:0] pin_out_bank1,
  output logic      [31:0] pin_oe_bank0,
  output logic      [31:0] pin_oe_bank1
);

  // refuse word register counts that do not fit the 32-word windows
  if (WORD_PINS0 < 1 || WORD_PINS0 > 32 || WORD_PINS1 < 1 || WORD_PINS1 > 32) begin : g_bad_params
    $error("word pin count must lie between 1 and 32");
  end

  // word register window hit: aligned, inside base .. base + 4*(count-1)
  function automatic logic word_hit(input logic [31:0] addr, input logic [31:0] base, input int count);
    logic [31:0] ofs;
    ofs = addr - base;
    return (addr >= base) && (addr[1:0] == 2'b00) &&
           (ofs[31:`WORD_STRIDE_LOG2] < 30'(count));
  endfunction : word_hit

  // full address decode, shared by the read and the write paths
  function automatic reg_sel_e decode(input logic [31:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (word_hit(addr, `WORD_BANK0_BASE, WORD_PINS0)) begin
      sel = SEL_WORD0;
    end else if (word_hit(addr, `WORD_BANK1_BASE, WORD_PINS1)) begin
      sel = SEL_WORD1;
    end else begin
      case (addr)
        `DIR_BANK0_ADDR:  sel = SEL_DIRECTION_BANK0;
        `DIR_BANK1_ADDR:  sel = SEL_DIR1;
        `MASK_BANK0_ADDR: sel = SEL_MASKED_ACCESS_ENABLE_BANK0;
        `MASK_BANK1_ADDR: sel = SEL_MASKED_ACCESS_ENABLE_BANK1;
        `PIN_BANK0_ADDR:  sel = SEL_PIN_LEVEL_BANK0;
        `PIN_BANK1_ADDR:  sel = SEL_PIN_LEVEL_BANK1;
        `MPIN_BANK0_ADDR: sel = SEL_MPIN0;
        `MPIN_BANK1_ADDR: sel = SEL_MPIN1;
        default:          sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode

  // storage: output bits, directions and masks per port
  logic [1:0][31:0] out_q;
  logic [1:0][31:0] out_d;
  logic [1:0][31:0] dir_q;
  logic [1:0][31:0] mask_q;
  logic [1:0][31:0] oe_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;

  // three-stage pin synchroniser and the filtered level
  logic [1:0][31:0] sync1_q;
  logic [1:0][31:0] sync2_q;
  logic [1:0][31:0] sync3_q;
  logic [1:0][31:0] level_q;
  logic [1:0][31:0] pin_raw;
  logic [1:0][31:0] analog_sel;
  logic [1:0][31:0] gpio_sel;
  logic [1:0][31:0] pin_val;

  reg_sel_e         sel;
  logic [4:0]       word_idx;
  logic             word_set;

  assign pin_raw    = {pin_in_bank1, pin_in_bank0};
  assign analog_sel = {analog_sel_bank1, analog_sel_bank0};
  assign gpio_sel   = {gpio_sel_bank1, gpio_sel_bank0};
  assign sel        = decode(bus_addr);
  assign word_idx   = bus_addr[6:2];
  assign word_set   = |bus_wdata;

  // pins are asynchronous; the first stage is read only by the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (clk_en) begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a bit changes only once stages two and three agree, which hides a
  // single-cycle metastable settle at the cost of one extra cycle of delay
  for (genvar b = 0; b < 2; b++) begin : g_level
    for (genvar i = 0; i < 32; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          level_q[b][i] <= 1'b0;
        end else if (clk_en && (sync2_q[b][i] == sync3_q[b][i])) begin
          level_q[b][i] <= sync3_q[b][i];
        end
      end
    end
  end

  // readable pin state; analog pins always read zero
  assign pin_val = level_q & ~analog_sel;

  // direction registers, both reset to inputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= {2{`DIR_RESET}};
    end else if (clk_en && bus_wr) begin
      if (sel == SEL_DIRECTION_BANK0) begin
        dir_q[0] <= bus_wdata;
      end
      if (sel == SEL_DIR1) begin
        dir_q[1] <= bus_wdata;
      end
    end
  end

  // mask registers; reset leaves every bit enabled for masked access
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= {2{`MASK_RESET}};
    end else if (clk_en && bus_wr) begin
      if (sel == SEL_MASKED_ACCESS_ENABLE_BANK0) begin
        mask_q[0] <= bus_wdata;
      end
      if (sel == SEL_MASKED_ACCESS_ENABLE_BANK1) begin
        mask_q[1] <= bus_wdata;
      end
    end
  end

  // next output bits; only the masked path consults the mask
  always_comb begin
    out_d = out_q;
    if (bus_wr) begin
      unique case (sel)
        SEL_WORD0: out_d[0][word_idx] = word_set;
        SEL_WORD1: out_d[1][word_idx] = word_set;
        SEL_PIN_LEVEL_BANK0:  out_d[0] = bus_wdata;
        SEL_PIN_LEVEL_BANK1:  out_d[1] = bus_wdata;
        SEL_MPIN0: out_d[0] = (out_q[0] & mask_q[0]) | (bus_wdata & ~mask_q[0]);
        SEL_MPIN1: out_d[1] = (out_q[1] & mask_q[1]) | (bus_wdata & ~mask_q[1]);
        SEL_NONE, SEL_DIRECTION_BANK0, SEL_DIR1, SEL_MASKED_ACCESS_ENABLE_BANK0, SEL_MASKED_ACCESS_ENABLE_BANK1: out_d = out_q;
      endcase
    end
  end

  // output bit storage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= {2{`OUT_RESET}};
    end else if (clk_en) begin
      out_q <= out_d;
    end
  end

  // pin drive enable is registered so the pads see a clean level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oe_q <= '0;
    end else if (clk_en) begin
      oe_q <= gpio_sel & dir_q;
    end
  end

  // read mux; unmapped addresses and strobe-less cycles return zero
  always_comb begin
    rdata_d = `WORD_ZERO;
    if (bus_rd) begin
      unique case (sel)
        SEL_WORD0: rdata_d = pin_val[0][word_idx] ? `WORD_ALL_ONES : `WORD_ZERO;
        SEL_WORD1: rdata_d = pin_val[1][word_idx] ? `WORD_ALL_ONES : `WORD_ZERO;
        SEL_DIRECTION_BANK0:  rdata_d = dir_q[0];
        SEL_DIR1:  rdata_d = dir_q[1];
        SEL_MASKED_ACCESS_ENABLE_BANK0: rdata_d = mask_q[0];
        SEL_MASKED_ACCESS_ENABLE_BANK1: rdata_d = mask_q[1];
        SEL_PIN_LEVEL_BANK0:  rdata_d = pin_val[0];
        SEL_PIN_LEVEL_BANK1:  rdata_d = pin_val[1];
        SEL_MPIN0: rdata_d = pin_val[0] & ~mask_q[0];
        SEL_MPIN1: rdata_d = pin_val[1] & ~mask_q[1];
        SEL_NONE:  rdata_d = `WORD_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `WORD_ZERO;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // every output straight from a flip-flop
  assign bus_rdata     = rdata_q;
  assign pin_out_bank0 = out_q[0];
  assign pin_out_bank1 = out_q[1];
  assign pin_oe_bank0  = oe_q[0];
  assign pin_oe_bank1  = oe_q[1];

endmodule : gpio_port_pin_access

// ---- gpio_port_pin_access_properties.sv ----
// concurrent checks on the ports of the gpio port pin access block
// assumes one clock ref_clk and asynchronous active-low nrst
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module gpio_port_checker #(
  parameter int WORD_PINS0 = 24,
  parameter int WORD_PINS1 = 32
) (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [31:0] gpio_sel_bank0,
  input wire logic [31:0] pin_out_bank0,
  input wire logic [31:0] pin_out_bank1,
  input wire logic [31:0] pin_oe_bank0
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // qualified strobes; word decode keeps bank0 indices past the pin count unmapped
  logic wr, rd, wa;
  assign wr = bus_wr & clk_en;
  assign rd = bus_rd & clk_en;
  assign wa = bus_addr[31:8] == `WORD_BANK0_BASE >> 8 && bus_addr[1:0] == 2'h0
              && (bus_addr[7] ? bus_addr[6:2] < WORD_PINS1 : bus_addr[6:2] < WORD_PINS0);
  property p_rd_idle;
    clk_en && !bus_rd |=> bus_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_word_rd;
    rd && bus_addr[31:8] == `WORD_BANK0_BASE >> 8 |=> bus_rdata inside {32'h0000_0000, 32'hFFFF_FFFF};
  endproperty
  a_word_rd: assert property (p_word_rd) else $error("word read not uniform");
  property p_word0_wr;
    wr && wa && !bus_addr[7] |=> pin_out_bank0[$past(bus_addr[6:2])] == ($past(bus_wdata) != 0);
  endproperty
  a_word0_wr: assert property (p_word0_wr) else $error("word write bank0");
  property p_word1_wr;
    wr && wa && bus_addr[7] |=> pin_out_bank1[$past(bus_addr[6:2])] == ($past(bus_wdata) != 0);
  endproperty
  a_word1_wr: assert property (p_word1_wr) else $error("word write bank1");
  property p_pin_wr;
    wr && bus_addr == `PIN_BANK0_ADDR |=> pin_out_bank0 == $past(bus_wdata);
  endproperty
  a_pin_wr: assert property (p_pin_wr) else $error("port write not loaded");
  property p_out_hold;
    clk_en && !bus_wr |=> $stable(pin_out_bank0) && $stable(pin_out_bank1);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved without write");
  property p_oe_sel;
    clk_en |=> (pin_oe_bank0 & ~$past(gpio_sel_bank0)) == 32'h0000_0000;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("drive on unselected pin");
  property p_dir_oe;
    wr && bus_addr == `DIR_BANK0_ADDR ##1 clk_en |=> pin_oe_bank0 == ($past(bus_wdata, 2) & $past(gpio_sel_bank0));
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("enable not from direction");
endmodule : gpio_port_checker
bind gpio_port_pin_access gpio_port_checker #(.WORD_PINS0(WORD_PINS0), .WORD_PINS1(WORD_PINS1)) u_chk (
  .ref_clk, .nrst, .clk_en, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
  .gpio_sel_bank0, .pin_out_bank0, .pin_out_bank1, .pin_oe_bank0);

// ---- pin_partner.sv ----
// far-side pins of one port
// assumes ext stands for whatever else on the board drives a released pin
`timescale 1ns/100ps
module pin_partner (
  input  wire logic [31:0] drv,
  input  wire logic [31:0] oe,
  input  wire logic [31:0] ext,
  output logic      [31:0] lvl
);
  // a released pin follows the outside source, never the last driven value
  assign lvl = (oe & drv) | (~oe & ext);
endmodule : pin_partner

// ---- test_gpio_port_pin_access.sv ----
// self-checking bench for the gpio port pin access block
// assumes pin_partner on both ports and the bound checker
`timescale 1ns/100ps
`include "gpio_port_defines.svh"
module test_gpio_port_pin_access import gpio_port_pkg::*;;
  logic  ref_clk, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, rd_q = 1'b0, en = 1'b1;
  word_t bus_addr = '0, bus_wdata = '0, bus_rdata, out[2], oe[2], lv[2];
  word_t gs[2] = '{0, 0}, ext[2] = '{0, 0}, an[2] = '{0, 0};
  word_t dir[2] = '{0, 0}, msk[2] = '{0, 0}, mo[2] = '{0, 0}, exp_q[$];
  int    fails = 0, samples_checked = 0;
  gpio_port_pin_access u_dut (.ref_clk, .nrst, .clk_en(en), .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .pin_in_bank0(lv[0]), .pin_in_bank1(lv[1]), .gpio_sel_bank0(gs[0]), .gpio_sel_bank1(gs[1]),
    .analog_sel_bank0(an[0]), .analog_sel_bank1(an[1]), .pin_out_bank0(out[0]), .pin_out_bank1(out[1]),
    .pin_oe_bank0(oe[0]), .pin_oe_bank1(oe[1]));
  pin_partner u_p0 (.drv(out[0]), .oe(oe[0]), .ext(ext[0]), .lvl(lv[0]));
  pin_partner u_p1 (.drv(out[1]), .oe(oe[1]), .ext(ext[1]), .lvl(lv[1]));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(word_t got, word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // word range; bank0 indices past its pin count are unmapped
  function automatic bit wb(word_t a);
    return a[31:8] == `WORD_BANK0_BASE >> 8 && a[1:0] == 2'h0 && (a[7] || a[6:2] < `WORD_PINS_BANK0);
  endfunction : wb
  function automatic word_t lvl(bit b);
    return ((gs[b] & dir[b] & mo[b]) | (~(gs[b] & dir[b]) & ext[b])) & ~an[b];
  endfunction : lvl
  function automatic word_t exp_rd(word_t a);
    word_t l;
    l = lvl(wb(a) ? a[7] : a[2]);
    if (wb(a)) return {32{l[a[6:2]]}};
    if (a[1:0] != 2'h0) return '0;
    case ({a[31:3], 3'h0})
      `DIR_BANK0_ADDR:  return dir[a[2]];
      `MASK_BANK0_ADDR: return msk[a[2]];
      `PIN_BANK0_ADDR:  return l;
      `MPIN_BANK0_ADDR: return l & ~msk[a[2]];
      default:          return '0;
    endcase
  endfunction : exp_rd
  function automatic void mdl_wr(word_t a, word_t d);
    if (wb(a)) mo[a[7]][a[6:2]] = |d;
    else if (a[1:0] == 2'h0)
      case ({a[31:3], 3'h0})
        `DIR_BANK0_ADDR:  dir[a[2]] = d;
        `MASK_BANK0_ADDR: msk[a[2]] = d;
        `PIN_BANK0_ADDR:  mo[a[2]] = d;
        `MPIN_BANK0_ADDR: mo[a[2]] = (mo[a[2]] & msk[a[2]]) | (d & ~msk[a[2]]);
        default: ;
      endcase
  endfunction : mdl_wr
  // strobe is left high so calls run back to back; idle drops it
  task automatic acc(bit w, word_t a, word_t d);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_wdata <= d;
    if (w) mdl_wr(a, d);
    else exp_q.push_back(exp_rd(a));
    @(posedge ref_clk);
  endtask : acc
  task automatic idle(int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_q) chk(bus_rdata, exp_q.pop_front());
    rd_q <= bus_rd;
  end
  // every control and access register, the unused set pair, and a misaligned word
  task automatic sweep();
    for (int i = 0; i < 10; i++) acc(0, `DIR_BANK0_ADDR + {i[3:1], 4'h0, i[0], 2'h0}, '0);
    acc(0, `WORD_BANK0_BASE + 32'h0000_0001, '0);
    for (int k = 0; k < 64; k++) acc(0, `WORD_BANK0_BASE + {k[5:0], 2'h0}, '0);
    idle(2);
    for (int b = 0; b < 2; b++) begin
      chk(out[b], mo[b]);
      chk(oe[b], gs[b] & dir[b]);
    end
  endtask : sweep
  initial begin
    word_t r;
    void'($urandom(32'h4138_bb67));
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(2);
    sweep();
    repeat (40) begin
      for (int b = 0; b < 2; b++) begin
        gs[b] <= $urandom;
        ext[b] <= $urandom;
        an[b] <= $urandom & $urandom & $urandom;
      end
      repeat (4) begin
        r = $urandom;
        acc(1, r[0] ? `WORD_BANK0_BASE + {r[7:2], 2'h0} : `DIR_BANK0_ADDR + {r[4:2], 4'h0, r[5], 2'h0},
            r[10:9] == 2'h0 ? '0 : $urandom);
      end
      // pins pass a synchroniser, so let the new levels settle before reading
      idle(8);
      sweep();
    end
    // a write strobe while the clock enable is low must leave the outputs alone
    en <= 1'b0;
    bus_wr <= 1'b1;
    bus_addr <= `PIN_BANK0_ADDR;
    bus_wdata <= ~mo[0];
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    en <= 1'b1;
    idle(2);
    chk(out[0], mo[0]);
    close_out();
  end
  // a pass takes about four thousand cycles; five times that is a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end
endmodule : test_gpio_port_pin_access
